// >>> logic/szag_guard.sv
// Secure zone access guard: zone ownership, per-access checks, unlock sequencing
`timescale 1ns/1ps
`default_nettype none
module szag_guard
	import szag_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire szag_pkg::szag_src_t acc_src,
	input wire logic [szag_pkg::szag_addr_w-1:0] acc_addr,
	input wire logic [szag_pkg::szag_addr_w-1:0] acc_pc,
	input wire logic [szag_pkg::szag_data_w-1:0] mem_rdata,
	input wire logic [2*szag_pkg::szag_num_ram-1:0] zone_ram_claim,
	input wire logic [2*szag_pkg::szag_num_sect-1:0] zone_flash_sector_claim,
	input wire logic [3*szag_pkg::szag_key_words*32-1:0] zone_unlock_key,
	input wire logic pwd_start,
	input wire logic [1:0] pwd_zone,
	output logic mem_req,
	output logic mem_we,
	output logic [szag_pkg::szag_addr_w-1:0] mem_addr,
	output logic rdata_valid,
	output logic [szag_pkg::szag_data_w-1:0] acc_rdata,
	output logic acc_blocked,
	output logic pwd_busy,
	output logic [2:0] zone_locked
);
	import szag_pkg::*;

	// ==========================================================
	// Zone ownership decode
	// ==========================================================
	// Ownership comes from claims, with two sectors and the control region hard-wired
	function automatic logic [1:0] zone_of(input logic [szag_addr_w-1:0] a,
		input logic [2*szag_num_ram-1:0] rc, input logic [2*szag_num_sect-1:0] sc);
		int idx;
		zone_of = szag_zone_none;
		idx = 0;
		if (a >= szag_ctl_base && a <= szag_ctl_top) begin
			zone_of = szag_zone_ctl;
		end else if (a >= szag_flash_base) begin
			idx = int'((a - szag_flash_base) >> szag_sect_shift);
			if (idx == szag_sect_last) begin
				zone_of = szag_zone_one;
			end else if (idx == szag_sect_first) begin
				zone_of = szag_zone_two;
			end else if (idx < szag_num_sect) begin
				zone_of = sc[2*idx +: 2];
			end
		end else begin
			idx = int'(a >> szag_ram_shift);
			if (idx < szag_num_ram) begin
				zone_of = rc[2*idx +: 2];
			end
		end
	endfunction : zone_of

	// Sector holding each zone's password, fixed per zone
	function automatic logic [szag_addr_w-1:0] pwd_base(input logic [1:0] z);
		logic [szag_addr_w-1:0] sect;
		sect = 20'h00000;
		unique case (z)
			szag_zone_one: sect = szag_addr_w'(szag_sect_last) << szag_sect_shift;
			szag_zone_two: sect = szag_addr_w'(szag_sect_first) << szag_sect_shift;
			default: sect = szag_ctl_base - szag_flash_base;
		endcase
		pwd_base = szag_flash_base + sect + szag_pwd_off;
	endfunction : pwd_base

	// ==========================================================
	// Zone lock engines
	// ==========================================================
	logic [2:0] lock_w;
	logic [2:0] pwd_valid_w;
	logic [szag_key_words*32-1:0] pwd_reg, pwd_next;
	genvar g;
	generate
		for (g = 0; g < szag_num_zones; g++) begin : g_zone
			szag_zone_lock u_lock (
				.sys_clk(sys_clk),
				.rst(rst),
				.zone_unlock_key(zone_unlock_key[g*szag_key_words*32 +: szag_key_words*32]),
				.pwd_valid(pwd_valid_w[g]),
				.pwd_value(pwd_reg),
				.locked(lock_w[g])
			);
		end
	endgenerate

	// ==========================================================
	// Access check and password read sequencer
	// ==========================================================
	szag_state_t st_reg, st_next;
	logic [1:0] wcnt_reg, wcnt_next;
	logic [1:0] pz_reg, pz_next;
	logic mem_req_reg, mem_req_next;
	logic mem_we_reg, mem_we_next;
	logic [szag_addr_w-1:0] mem_addr_reg, mem_addr_next;
	logic rv_reg, rv_next;
	logic [szag_data_w-1:0] rd_reg, rd_next;
	logic blk_reg, blk_next;
	logic pend_reg, pend_next;
	logic pend_blk_reg, pend_blk_next;
	logic [1:0] tz, pcz;
	logic tgt_locked, deny;

	always_comb begin
		tz = zone_of(acc_addr, zone_ram_claim, zone_flash_sector_claim);
		pcz = zone_of(acc_pc, zone_ram_claim, zone_flash_sector_claim);
		tgt_locked = (tz != szag_zone_none) && lock_w[tz - 2'h1];
		deny = 1'b0;
		if (tgt_locked) begin
			if (acc_src != szag_src_cpu) begin
				deny = 1'b1;
			end else if (pcz != tz) begin
				deny = 1'b1;
			end // Code inside the same zone passes
		end
		st_next = st_reg;
		wcnt_next = wcnt_reg;
		pz_next = pz_reg;
		pwd_next = pwd_reg;
		mem_req_next = 1'b0;
		mem_we_next = 1'b0;
		mem_addr_next = mem_addr_reg;
		rv_next = 1'b0;
		rd_next = rd_reg;
		blk_next = 1'b0;
		pend_next = 1'b0;
		pend_blk_next = 1'b0;
		// Memory returns data in the same cycle the request is on mem_req
		if (pend_reg) begin
			rv_next = 1'b1;
			rd_next = pend_blk_reg ? '0 : mem_rdata;
		end
		unique case (st_reg)
			szag_st_idle: begin
				// CPU accesses never stall; a blocked read completes with zero
				if (acc_valid) begin
					mem_req_next = !deny;
					mem_we_next = acc_write && !deny;
					mem_addr_next = acc_addr;
					blk_next = deny;
					pend_next = !acc_write;
					pend_blk_next = deny;
				end else if (pwd_start && pwd_zone != szag_zone_none) begin
					st_next = szag_st_read;
					pz_next = pwd_zone;
					wcnt_next = 2'h0;
				end
			end
			szag_st_read: begin
				mem_req_next = 1'b1;
				mem_addr_next = pwd_base(pz_reg) + {wcnt_reg, 2'h0};
				st_next = szag_st_cmp;
			end
			szag_st_cmp: begin
				if (pend_reg) begin
					pwd_next[32*wcnt_reg +: 32] = mem_rdata;
					if (wcnt_reg == 2'h3) begin
						st_next = szag_st_idle;
					end else begin
						wcnt_next = wcnt_reg + 2'h1;
						st_next = szag_st_read;
					end
				end
			end
			default: st_next = szag_st_idle;
		endcase
		if (st_reg == szag_st_read) begin
			pend_next = 1'b1;
		end
		// Engine read data is not flagged valid to the requester, but the word still reaches acc_rdata
		if (st_reg == szag_st_cmp) begin
			rv_next = 1'b0;
		end
	end

	// Compare fires the cycle after the last word lands
	logic fire_reg;
	logic [1:0] fz_reg;
	// Busy is registered from the next state so the port comes from a flop
	logic busy_reg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fire_reg <= 1'b0;
			fz_reg <= 2'h0;
			busy_reg <= 1'b0;
		end else begin
			fire_reg <= (st_reg == szag_st_cmp) && pend_reg && (wcnt_reg == 2'h3);
			fz_reg <= pz_reg;
			busy_reg <= (st_next != szag_st_idle);
		end
	end
	// Only the zone whose password was read gets the compare strobe
	generate
		for (g = 0; g < szag_num_zones; g++) begin : g_fire
			assign pwd_valid_w[g] = fire_reg && (fz_reg == 2'(g + 1));
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= szag_st_idle;
			wcnt_reg <= 2'h0;
			pz_reg <= szag_zone_none;
			pwd_reg <= '0;
			mem_req_reg <= 1'b0;
			mem_we_reg <= 1'b0;
			mem_addr_reg <= '0;
			rv_reg <= 1'b0;
			rd_reg <= '0;
			blk_reg <= 1'b0;
			pend_reg <= 1'b0;
			pend_blk_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			wcnt_reg <= wcnt_next;
			pz_reg <= pz_next;
			pwd_reg <= pwd_next;
			mem_req_reg <= mem_req_next;
			mem_we_reg <= mem_we_next;
			mem_addr_reg <= mem_addr_next;
			rv_reg <= rv_next;
			rd_reg <= rd_next;
			blk_reg <= blk_next;
			pend_reg <= pend_next;
			pend_blk_reg <= pend_blk_next;
		end
	end

	assign mem_req = mem_req_reg;
	assign mem_we = mem_we_reg;
	assign mem_addr = mem_addr_reg;
	assign rdata_valid = rv_reg;
	assign acc_rdata = rd_reg;
	assign acc_blocked = blk_reg;
	assign pwd_busy = busy_reg;
	assign zone_locked = lock_w;

	chk_debug_blocked: assert property (@(posedge sys_clk) disable iff (rst)
		acc_valid && st_reg == szag_st_idle && acc_src == szag_src_dbg && tgt_locked
		|=> acc_blocked && !mem_req)
		else $error("debug access to locked zone passed");
	chk_blocked_zero: assert property (@(posedge sys_clk) disable iff (rst)
		acc_valid && st_reg == szag_st_idle && !acc_write && deny
		|=> ##1 rdata_valid && acc_rdata == '0)
		else $error("blocked read did not return zero");
	chk_secure_code_ok: assert property (@(posedge sys_clk) disable iff (rst)
		acc_valid && st_reg == szag_st_idle && acc_src == szag_src_cpu && tz != szag_zone_none
		&& pcz == tz |=> !acc_blocked && mem_req)
		else $error("code in zone was blocked");
	chk_unsecure_pc: assert property (@(posedge sys_clk) disable iff (rst)
		acc_valid && st_reg == szag_st_idle && tgt_locked && pcz != tz |=> acc_blocked)
		else $error("unsecure code reached locked zone");
	chk_fixed_sectors: assert property (@(posedge sys_clk) disable iff (rst)
		acc_valid && acc_addr[szag_addr_w-1:szag_sect_shift]
		== 5'(int'(szag_flash_base >> szag_sect_shift) + szag_sect_last) |-> tz == szag_zone_one)
		else $error("last sector not owned by zone one");
	chk_first_sector: assert property (@(posedge sys_clk) disable iff (rst)
		acc_valid && acc_addr[szag_addr_w-1:szag_sect_shift]
		== 5'(int'(szag_flash_base >> szag_sect_shift) + szag_sect_first) |-> tz == szag_zone_two)
		else $error("first sector not owned by zone two");
	chk_pwd_reads: assert property (@(posedge sys_clk) disable iff (rst)
		st_reg == szag_st_idle && !acc_valid && pwd_start && pwd_zone != 2'h0
		|=> ##1 mem_req && mem_addr == pwd_base(pz_reg))
		else $error("password read not issued");
	chk_no_stall: assert property (@(posedge sys_clk) disable iff (rst)
		acc_valid && st_reg == szag_st_idle && !acc_write |=> ##1 rdata_valid)
		else $error("read answer missing");
	chk_claim_map: assert property (@(posedge sys_clk) disable iff (rst)
		acc_valid && st_reg == szag_st_idle && acc_addr < szag_ctl_base
		&& acc_addr[szag_addr_w-1:szag_ram_shift] == '0 |-> tz == zone_ram_claim[1:0])
		else $error("ram claim not honoured");
endmodule : szag_guard
`default_nettype wire

// >>> logic/szag_pkg.sv
// Package of constants and types for the secure zone access guard
package szag_pkg;
	localparam int szag_addr_w = 20;
	localparam int szag_data_w = 32;
	localparam int szag_key_words = 4;
	localparam int szag_num_ram = 8;
	localparam int szag_num_sect = 14;
	localparam int szag_num_zones = 3;
	// Zone indices: two master zones, one control zone
	localparam logic [1:0] szag_zone_none = 2'h0;
	localparam logic [1:0] szag_zone_one = 2'h1;
	localparam logic [1:0] szag_zone_two = 2'h2;
	localparam logic [1:0] szag_zone_ctl = 2'h3;
	// Fixed sector owners
	localparam int szag_sect_first = 0;
	localparam int szag_sect_last = szag_num_sect - 1;
	// Region layout of the address space
	localparam logic [szag_addr_w-1:0] szag_ram_base = 20'h00000;
	localparam int szag_ram_shift = 13;
	localparam logic [szag_addr_w-1:0] szag_flash_base = 20'h80000;
	localparam int szag_sect_shift = 15;
	localparam logic [szag_addr_w-1:0] szag_ctl_base = 20'h40000;
	localparam logic [szag_addr_w-1:0] szag_ctl_top = 20'h4ffff;
	// Password word offset inside the owning sector
	localparam logic [szag_addr_w-1:0] szag_pwd_off = 20'h07ff0;
	// Claim field encoding, two bits per resource
	localparam logic [1:0] szag_claim_none = 2'h0;
	// Reset values
	localparam logic [31:0] szag_key_rst = 32'h00000000;
	localparam logic [1:0] szag_claim_rst = 2'h0;
	// Source of an access
	typedef enum logic [1:0] {
		szag_src_cpu,
		szag_src_dbg,
		szag_src_ext
	} szag_src_t;
	// Unlock engine states
	typedef enum logic [1:0] {
		szag_st_idle,
		szag_st_read,
		szag_st_cmp
	} szag_state_t;
endpackage : szag_pkg

// >>> logic/szag_zone_lock.sv
// Per-zone password compare and lock state
`timescale 1ns/1ps
`default_nettype none
module szag_zone_lock
	import szag_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [szag_key_words*32-1:0] zone_unlock_key,
	input wire logic pwd_valid,
	input wire logic [szag_key_words*32-1:0] pwd_value,
	output logic locked
);
	import szag_pkg::*;
	logic locked_reg, locked_next;
	logic all_ones, all_zero;

	always_comb begin
		all_ones = &pwd_value;
		all_zero = ~|pwd_value;
		locked_next = locked_reg;
		if (pwd_valid) begin
			if (all_zero) begin
				locked_next = 1'b1;
			end else if (all_ones) begin
				locked_next = 1'b0;
			end else if (zone_unlock_key == pwd_value) begin
				locked_next = 1'b0;
			end else begin
				locked_next = 1'b1;
			end
		end
	end

	// Locked out of reset until the password has been read
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			locked_reg <= 1'b1;
		end else begin
			locked_reg <= locked_next;
		end
	end
	assign locked = locked_reg;

	chk_zero_never_unlocks: assert property (@(posedge sys_clk) disable iff (rst)
		pwd_valid && all_zero |=> locked_reg)
		else $error("all-zero password unlocked the zone");
	chk_ones_unlock: assert property (@(posedge sys_clk) disable iff (rst)
		pwd_valid && all_ones |=> !locked_reg)
		else $error("erased password left zone locked");
	chk_key_match: assert property (@(posedge sys_clk) disable iff (rst)
		pwd_valid && !all_zero && zone_unlock_key != pwd_value && !all_ones |=> locked_reg)
		else $error("wrong key unlocked the zone");
endmodule : szag_zone_lock
`default_nettype wire

// >>> tb/szag_mem_model.sv
// Memory model behind the guard: data words and the three password areas
`timescale 1ns/1ps
`default_nettype none
module szag_mem_model
	import szag_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [szag_pkg::szag_addr_w-1:0] mem_addr,
	input wire logic [127:0] pwd_one,
	input wire logic [127:0] pwd_two,
	input wire logic [127:0] pwd_ctl,
	output logic [szag_pkg::szag_data_w-1:0] mem_rdata
);
	import szag_pkg::*;
	localparam logic [19:0] pa_one = 20'(szag_flash_base + (szag_sect_last << szag_sect_shift)
		+ szag_pwd_off);
	localparam logic [19:0] pa_two = 20'(szag_flash_base + szag_pwd_off);
	localparam logic [19:0] pa_ctl = 20'(szag_ctl_base + szag_pwd_off);
	function automatic logic [31:0] word_at(input logic [19:0] a);
		int w;
		w = a[3:2];
		if (a[19:4] == pa_one[19:4]) return pwd_one[w*32 +: 32];
		if (a[19:4] == pa_two[19:4]) return pwd_two[w*32 +: 32];
		if (a[19:4] == pa_ctl[19:4]) return pwd_ctl[w*32 +: 32];
		return {12'h5a5, a};
	endfunction : word_at
	// Read data stands only while the request does; its inverse otherwise catches a late sample
	always_comb begin
		if (rst) begin
			mem_rdata = 32'h0;
		end else if (mem_req && !mem_we) begin
			mem_rdata = word_at(mem_addr);
		end else begin
			mem_rdata = ~word_at(mem_addr);
		end
	end
endmodule : szag_mem_model
`default_nettype wire

// >>> tb/test_secure_zone_access_guard.sv
// Self-checking bench for the secure zone access guard
`timescale 1ns/1ps
`default_nettype none
module test_secure_zone_access_guard;
	import szag_pkg::*;
	logic sys_clk = 0, rst = 1, acc_valid = 0, acc_write = 0, pwd_start = 0;
	szag_src_t acc_src = szag_src_cpu;
	logic [19:0] acc_addr = 0, acc_pc = 0, mem_addr;
	logic [31:0] mem_rdata, acc_rdata, x = 32'd20;
	logic [15:0] ram_c = 16'h0039;
	logic [27:0] sect_c = 28'h8002401;
	logic [383:0] keys = '0;
	logic [1:0] pwd_zone = 0;
	logic [127:0] pw_one, pw_two = '1, pw_ctl = '0;
	logic mem_req, mem_we, rdata_valid, acc_blocked, pwd_busy;
	logic [2:0] zone_locked, exp_lk = 3'h7;
	logic [19:0] bases [10] = '{20'h00000, 20'h02000, 20'h04000, 20'h0e000, 20'h40000,
		20'h80000, 20'ha8000, 20'hb0000, 20'he8000, 20'h88000};
	int num_errors = 0, n_checks = 0, cyc = 0;
	always #12.5 sys_clk = ~sys_clk;
	szag_guard dut (.sys_clk(sys_clk), .rst(rst), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_src(acc_src), .acc_addr(acc_addr), .acc_pc(acc_pc), .mem_rdata(mem_rdata),
		.zone_ram_claim(ram_c), .zone_flash_sector_claim(sect_c), .zone_unlock_key(keys),
		.pwd_start(pwd_start), .pwd_zone(pwd_zone), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .rdata_valid(rdata_valid), .acc_rdata(acc_rdata),
		.acc_blocked(acc_blocked), .pwd_busy(pwd_busy), .zone_locked(zone_locked));
	szag_mem_model mem (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .pwd_one(pw_one), .pwd_two(pw_two), .pwd_ctl(pw_ctl),
		.mem_rdata(mem_rdata));
	function automatic logic [31:0] rnd();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : rnd
	function automatic logic [1:0] zone_of(input logic [19:0] a);
		logic [19:0] s;
		if (a < 20'h10000) return 2'(ram_c >> (2 * a[15:13]));
		if (a >= szag_ctl_base && a <= szag_ctl_top) return szag_zone_ctl;
		if (a < szag_flash_base || a >= 20'hf0000) return szag_zone_none;
		s = (a - szag_flash_base) >> szag_sect_shift;
		if (s == 0) return szag_zone_two;
		if (s == 13) return szag_zone_one;
		return 2'(sect_c >> (2 * s));
	endfunction : zone_of
	function automatic logic exp_blk(input szag_src_t s, input logic [19:0] a, pc);
		logic [1:0] z;
		z = zone_of(a);
		if (z == 0 || !exp_lk[z-1]) return 1'b0;
		return s != szag_src_cpu || zone_of(pc) != z;
	endfunction : exp_blk
	task automatic chk_flag(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t flag got %b expected %b", $time, got, exp);
		end
	endtask : chk_flag
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t value got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task automatic do_acc(input logic w, input szag_src_t s, input logic [19:0] a, pc);
		logic b;
		int k;
		b = exp_blk(s, a, pc);
		acc_valid = 1;
		acc_write = w;
		acc_src = s;
		acc_addr = a;
		acc_pc = pc;
		@(negedge sys_clk);
		acc_valid = 0;
		chk_flag(acc_blocked, b);
		if (!b) begin
			chk_val({11'h0, mem_req, mem_addr}, {12'h1, a});
			chk_flag(mem_we, w);
		end else begin
			chk_flag(mem_req | mem_we, 1'b0);
		end
		k = 0;
		while (!w && rdata_valid !== 1'b1 && k < 4) begin
			@(negedge sys_clk);
			k++;
		end
		if (!w) chk_flag(rdata_valid, 1'b1);
		if (!w) chk_val(acc_rdata, b ? 32'h0 : {12'h5a5, a});
		@(negedge sys_clk);
	endtask : do_acc
	task automatic do_pwd(input int z, input logic [127:0] key, input logic lk);
		int k;
		keys[(z-1)*128 +: 128] = key;
		pwd_zone = 2'(z);
		pwd_start = 1;
		@(negedge sys_clk);
		pwd_start = 0;
		k = 0;
		@(negedge sys_clk);
		while (pwd_busy !== 1'b0 && k < 200) begin
			@(negedge sys_clk);
			k++;
		end
		chk_flag(pwd_busy, 1'b0);
		// Lock state follows one cycle after the last word is taken
		@(negedge sys_clk);
		exp_lk[z-1] = lk;
		chk_val({29'h0, zone_locked}, {29'h0, exp_lk});
	endtask : do_pwd
	task automatic rand_accs(input int n);
		logic [31:0] r;
		repeat (n) begin
			r = rnd();
			do_acc(r[0], szag_src_t'(r[2:1] % 3), bases[r[7:4] % 10] | 20'(r[20:8] & 13'h1ffc),
				bases[r[27:24] % 10] | 20'(r[12:8]));
		end
	endtask : rand_accs
	// Hang guard: the sequence needs well under two thousand cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		pw_one = {rnd(), rnd(), rnd(), rnd()};
		repeat (20) @(negedge sys_clk);
		rst = 0;
		chk_val({29'h0, zone_locked}, 32'h7);
		do_acc(1'b0, szag_src_dbg, 20'he8010, 20'he8000);
		do_acc(1'b0, szag_src_cpu, 20'he8010, 20'he8100);
		do_acc(1'b0, szag_src_cpu, 20'he8010, 20'h80100);
		do_acc(1'b1, szag_src_ext, 20'h00040, 20'h00000);
		rand_accs(40);
		do_pwd(1, pw_one ^ 128'h1, 1'b1);
		do_pwd(3, 128'h0, 1'b1);
		do_pwd(2, 128'h0, 1'b0);
		do_pwd(1, pw_one, 1'b0);
		do_acc(1'b0, szag_src_dbg, 20'he8010, 20'he8000);
		rand_accs(40);
		tally_and_finish();
	end
endmodule : test_secure_zone_access_guard
`default_nettype wire
